// [src/fpd_cfg.svh]
// Purpose: Named constants for the fan drive and speed monitor
// Assumes: 50 MHz mclk, temperature level given in millivolts
// Notes: Definitions only
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH

// ====================================================
// Timebase
`define FPD_CLK_HZ 32'h02FA_F080
`define FPD_PWM_HZ 32'h0000_001E
`define FPD_MS_PER_S 32'h0000_03E8
`define FPD_START_MS 32'h0000_03E8
`define FPD_HOLD_MS 32'h0000_0960

// ====================================================
// Duty scale in per mille
`define FPD_DUTY_FLOOR 10'h12C
`define FPD_DUTY_SPAN 10'h2BC
`define FPD_DUTY_FULL 10'h3E8
`define FPD_CODE_STEPS 4'hF
`define FPD_OPEN_CODE 4'h2
`define FPD_OPEN_DUTY 10'h189

// ====================================================
// Temperature input window in millivolts
`define FPD_VIN_LO 12'h654
`define FPD_VIN_HI 12'hA28
`define FPD_VIN_RANGE 12'h3D4

// ====================================================
// Register defaults and limits
`define FPD_LEVEL_RST 4'h2
`define FPD_SPEED_RST 9'h000
`define FPD_SPEED_MAX 9'h1FF
`define FPD_OT_ALARM 1'b1

`endif

// [src/fpd_pkg.sv]
// Purpose: Types shared by the fan drive modules
// Assumes: fpd_cfg.svh constants
// Notes: Duty values are per mille
`default_nettype none
`include "fpd_cfg.svh"

package fpd_pkg;

  // ====================================================
  // Drive sequencer states, one-hot
  typedef enum logic [2:0] {
    FPD_ST_SLEEP = 3'h1,
    FPD_ST_START = 3'h2,
    FPD_ST_RUN = 3'h4
  } fpd_state_e;

  typedef logic [9:0] fpd_duty_t; // Per mille duty

  // Register code to duty, equal steps from floor to full
  function automatic fpd_duty_t fpd_code_duty(input logic [3:0] code);
    logic [13:0] prod;
    prod = 14'(code) * 14'(`FPD_DUTY_SPAN);
    return `FPD_DUTY_FLOOR + 10'(prod / 14'(`FPD_CODE_STEPS));
  endfunction : fpd_code_duty

endpackage : fpd_pkg

`default_nettype wire

// [src/fpd_tach_if.sv]
// Purpose: Carrier between drive core and tachometer counter
// Assumes: One clock domain
// Notes: speed_code is in 25 RPM units
`default_nettype none

interface fpd_tach_if;
  logic enable; // Low holds the counter at defaults
  logic [1:0] ppr_sel; // Pulses per revolution select
  logic [8:0] speed_code; // Clamped speed, 25 RPM per step
  logic code_valid; // One-cycle pulse at gate end
  logic overflow; // Speed above maximum

  modport core (output enable, output ppr_sel, input speed_code, input code_valid, input overflow);
  modport tach (input enable, input ppr_sel, output speed_code, output code_valid, output overflow);
endinterface : fpd_tach_if

`default_nettype wire

// [src/fpd_tach.sv]
// Purpose: Counts tachometer pulses over a fixed gate and scales them
// Assumes: tach_pulse synchronous to mclk
// Notes: A 2.4 s gate makes one pulse per revolution equal 25 RPM
`default_nettype none
`include "fpd_cfg.svh"

module fpd_tach
  import fpd_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `FPD_CLK_HZ / `FPD_MS_PER_S * `FPD_HOLD_MS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tach_pulse,
  fpd_tach_if.tach tb
);

  logic tach_q; // Previous pulse level for edge detection
  logic [15:0] pulse_cnt; // Qualified pulses this gate
  logic [31:0] gate_cnt; // Cycles into the gate
  logic [15:0] raw_code; // Pulses divided by pulses per rev
  logic gate_end;

  assign gate_end = tb.enable && (gate_cnt == GATE_CYCLES - 1);
  assign raw_code = pulse_cnt >> tb.ppr_sel;

  // ====================================================
  // Pulse counting over the gate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tach_q <= 1'b0;
      pulse_cnt <= 16'h0000;
      gate_cnt <= 32'h0000_0000;
    end else if (!tb.enable) begin
      tach_q <= 1'b0;
      pulse_cnt <= 16'h0000;
      gate_cnt <= 32'h0000_0000;
    end else begin
      tach_q <= tach_pulse;
      gate_cnt <= gate_end ? 32'h0000_0000 : gate_cnt + 32'h0000_0001;
      // Only rising edges count, saturate so a noisy line cannot wrap
      // An edge in the closing cycle opens the next gate, so none is lost
      if (gate_end) begin
        pulse_cnt <= {15'h0000, tach_pulse && !tach_q};
      end else if (tach_pulse && !tach_q && pulse_cnt != 16'hFFFF) begin
        pulse_cnt <= pulse_cnt + 16'h0001;
      end
    end
  end

  // ====================================================
  // Result and overflow; one whole gate below maximum clears it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tb.speed_code <= `FPD_SPEED_RST;
      tb.overflow <= 1'b0;
      tb.code_valid <= 1'b0;
    end else if (!tb.enable) begin
      tb.speed_code <= `FPD_SPEED_RST;
      tb.overflow <= 1'b0;
      tb.code_valid <= 1'b0;
    end else begin
      tb.code_valid <= gate_end;
      if (gate_end) begin
        if (raw_code > 16'(`FPD_SPEED_MAX)) begin
          tb.speed_code <= `FPD_SPEED_MAX;
          tb.overflow <= 1'b1;
        end else begin
          tb.speed_code <= raw_code[8:0];
          tb.overflow <= 1'b0;
        end
      end
    end
  end

  AST_OVF_SET: assert property (@(posedge mclk) disable iff (rst)
    gate_end && raw_code > 16'(`FPD_SPEED_MAX) |=> tb.overflow && tb.speed_code == `FPD_SPEED_MAX)
    else $error("overflow not flagged with clamp");
  AST_OVF_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    gate_end && raw_code <= 16'(`FPD_SPEED_MAX) |=> !tb.overflow && tb.speed_code == $past(raw_code[8:0]))
    else $error("overflow kept after clean gate");

endmodule : fpd_tach

`default_nettype wire

// [src/fpd_top.sv]
// Purpose: Fan PWM drive with duty source select and speed monitor
// Assumes: Temperature level arrives digitised in millivolts
// Notes: Register framing is outside; config bits arrive as levels
`default_nettype none
`include "fpd_cfg.svh"

module fpd_top
  import fpd_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = `FPD_CLK_HZ / `FPD_PWM_HZ,
  parameter int unsigned START_CYCLES = `FPD_CLK_HZ / `FPD_MS_PER_S * `FPD_START_MS,
  parameter int unsigned HOLD_CYCLES = `FPD_CLK_HZ / `FPD_MS_PER_S * `FPD_HOLD_MS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sleep_bit,
  input wire logic drive_source_sel,
  input wire logic [1:0] pulses_per_rev_sel,
  input wire logic fine_step_select,
  input wire logic stall_flag_clear,
  input wire logic [7:0] fault_threshold,
  input wire logic [11:0] vin_mv,
  input wire logic vin_open,
  input wire logic tach_pulse,
  input wire logic drive_level_wr,
  input wire logic [3:0] drive_level_wdata,
  output logic [3:0] drive_level,
  output logic [8:0] speed_reading_reg,
  output logic overheat_flag,
  output logic stall_flag,
  output logic speed_count_overflow,
  output logic alarm_out,
  output logic alarm_oe,
  output logic pwm_out
);

  // ====================================================
  // Declarations
  fpd_state_e state; // Drive sequencer
  fpd_state_e next_state;
  logic [31:0] start_cnt; // Cycles spent at forced full drive
  logic [31:0] pwm_cnt; // Position in the PWM period
  logic [31:0] high_time; // Cycles high in the current period
  logic [31:0] next_high_time; // High time from the selected source
  logic pwm_wrap; // Last cycle of a period
  fpd_duty_t duty_vin; // Duty commanded by temperature
  fpd_duty_t duty_sel; // Duty of the selected source
  logic [11:0] vin_diff; // Level above the lower end
  logic [21:0] vin_prod; // Scaled level before division
  logic [41:0] ht_prod; // Period times duty
  logic [31:0] stall_cnt; // Cycles spent below threshold
  logic speed_low; // Speed under fault threshold
  logic stall_set; // Stall condition matured this cycle
  logic over_temp; // Temperature past the upper end
  logic asleep;

  fpd_tach_if tb ();

  assign asleep = (state == FPD_ST_SLEEP);
  assign pwm_wrap = (pwm_cnt == PWM_PERIOD - 1);

  // ====================================================
  // Tachometer counter, suspended in sleep
  assign tb.enable = !asleep;
  assign tb.ppr_sel = pulses_per_rev_sel;

  fpd_tach #(
    .GATE_CYCLES(HOLD_CYCLES)
  ) u_tach (
    .mclk(mclk),
    .rst(rst),
    .tach_pulse(tach_pulse),
    .tb(tb)
  );

  // ====================================================
  // Sequencer: sleep, forced start, run
  always_comb begin
    next_state = state;
    case (state)
      FPD_ST_SLEEP: begin
        // Waking always goes through the full drive start
        if (!sleep_bit) begin
          next_state = FPD_ST_START;
        end
      end
      FPD_ST_START: begin
        if (sleep_bit) begin
          next_state = FPD_ST_SLEEP;
        end else if (start_cnt == START_CYCLES - 1) begin
          next_state = FPD_ST_RUN;
        end
      end
      FPD_ST_RUN: begin
        // Sleep is the only way out of run; stall never stops it
        if (sleep_bit) begin
          next_state = FPD_ST_SLEEP;
        end
      end
      default: begin
        next_state = FPD_ST_START;
      end
    endcase
  end

  // State register; reset lands in the forced start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= FPD_ST_START;
    end else begin
      state <= next_state;
    end
  end

  // Startup timer, restarted whenever start is entered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_cnt <= 32'h0000_0000;
    end else if (state != FPD_ST_START) begin
      start_cnt <= 32'h0000_0000;
    end else if (start_cnt != START_CYCLES - 1) begin
      start_cnt <= start_cnt + 32'h0000_0001;
    end
  end

  // ====================================================
  // Level register; writes ignored while asleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_level <= `FPD_LEVEL_RST;
    end else if (asleep) begin
      drive_level <= `FPD_LEVEL_RST;
    end else if (drive_level_wr) begin
      drive_level <= drive_level_wdata;
    end
  end

  // ====================================================
  // Temperature mapping: floor, linear span, full
  always_comb begin
    vin_diff = vin_mv - `FPD_VIN_LO;
    vin_prod = 22'(vin_diff) * 22'(`FPD_DUTY_SPAN);
    if (vin_open) begin
      duty_vin = fpd_code_duty(`FPD_OPEN_CODE);
    end else if (vin_mv <= `FPD_VIN_LO) begin
      duty_vin = `FPD_DUTY_FLOOR;
    end else if (vin_mv >= `FPD_VIN_HI) begin
      duty_vin = `FPD_DUTY_FULL;
    end else begin
      duty_vin = `FPD_DUTY_FLOOR + 10'(vin_prod / 22'(`FPD_VIN_RANGE));
    end
  end

  // Source select is read live, so a change lands at the next period
  always_comb begin
    if (drive_source_sel) begin
      duty_sel = fpd_code_duty(drive_level);
    end else begin
      duty_sel = duty_vin;
    end
    ht_prod = 42'(PWM_PERIOD) * 42'(duty_sel);
    next_high_time = 32'(ht_prod / 42'(`FPD_DUTY_FULL));
  end

  // ====================================================
  // PWM period counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwm_cnt <= 32'h0000_0000;
    end else if (asleep || pwm_wrap) begin
      pwm_cnt <= 32'h0000_0000;
    end else begin
      pwm_cnt <= pwm_cnt + 32'h0000_0001;
    end
  end

  // High time: full in start and sleep, else loaded only at the wrap
  // so a mid-period change never cuts a pulse short
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_time <= PWM_PERIOD;
    end else if (state != FPD_ST_RUN) begin
      high_time <= PWM_PERIOD;
    end else if (pwm_wrap) begin
      high_time <= next_high_time;
    end
  end

  // Drive pin from a flop; the stall flag has no say here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else if (asleep) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (pwm_cnt < high_time);
    end
  end

  // ====================================================
  // Speed reading, coarse mode drops the lowest bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_reading_reg <= `FPD_SPEED_RST;
      speed_count_overflow <= 1'b0;
    end else begin
      speed_count_overflow <= tb.overflow;
      if (fine_step_select) begin
        speed_reading_reg <= tb.speed_code;
      end else begin
        speed_reading_reg <= {1'b0, tb.speed_code[8:1]};
      end
    end
  end

  // ====================================================
  // Stall detection; threshold counts in 50 RPM steps
  assign speed_low = (state == FPD_ST_RUN) && (tb.speed_code[8:1] < fault_threshold);
  assign stall_set = speed_low && (stall_cnt == HOLD_CYCLES - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stall_cnt <= 32'h0000_0000;
    end else if (!speed_low || stall_set) begin
      // Restart on maturity: a lasting fault re-raises after a fresh
      // hold, and a clear is not overridden on every cycle
      stall_cnt <= 32'h0000_0000;
    end else begin
      stall_cnt <= stall_cnt + 32'h0000_0001;
    end
  end

  // A fresh stall in the clearing cycle wins over the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stall_flag <= 1'b0;
    end else if (asleep) begin
      stall_flag <= 1'b0;
    end else if (stall_set) begin
      stall_flag <= 1'b1;
    end else if (stall_flag_clear) begin
      stall_flag <= 1'b0;
    end
  end

  // ====================================================
  // Overheat follows the level, clears when it falls back
  assign over_temp = !vin_open && (vin_mv > `FPD_VIN_HI);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overheat_flag <= 1'b0;
    end else begin
      overheat_flag <= over_temp && !asleep;
    end
  end

  // Open-drain alarm: only ever pulls low
  assign alarm_out = 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_oe <= 1'b0;
    end else begin
      alarm_oe <= stall_flag || (`FPD_OT_ALARM && overheat_flag);
    end
  end

  // ====================================================
  // Checks
  sequence seq_wake;
    state == FPD_ST_SLEEP && !sleep_bit ##1 state == FPD_ST_START;
  endsequence

  sequence seq_start_done;
    state == FPD_ST_START && !sleep_bit && start_cnt == START_CYCLES - 1 ##1 state == FPD_ST_RUN;
  endsequence

  // Level is judged as wake ends, since a host write may follow at once
  AST_WAKE_FULL: assert property (@(posedge mclk) disable iff (rst)
    seq_wake |-> drive_level == `FPD_LEVEL_RST ##1 pwm_out)
    else $error("wake did not start at full drive with defaults");
  AST_START_TO_RUN: assert property (@(posedge mclk) disable iff (rst)
    state == FPD_ST_START && !sleep_bit && start_cnt == START_CYCLES - 1 |-> seq_start_done)
    else $error("startup did not hand over to run");
  AST_SLEEP_STOPS: assert property (@(posedge mclk) disable iff (rst)
    asleep |=> !pwm_out)
    else $error("drive active in sleep");
  AST_RUN_PULSES: assert property (@(posedge mclk) disable iff (rst)
    state == FPD_ST_RUN && !sleep_bit && pwm_cnt == 32'h0000_0000 |=> pwm_out)
    else $error("run period did not start high");
  AST_SRC_REG: assert property (@(posedge mclk) disable iff (rst)
    drive_source_sel |-> duty_sel == fpd_code_duty(drive_level))
    else $error("register source not applied");
  AST_OPEN_DEFAULT: assert property (@(posedge mclk) disable iff (rst)
    !drive_source_sel && vin_open |-> duty_sel == `FPD_OPEN_DUTY)
    else $error("open input default wrong");
  AST_FLOOR: assert property (@(posedge mclk) disable iff (rst)
    !drive_source_sel && !vin_open && vin_mv <= `FPD_VIN_LO |-> duty_sel == `FPD_DUTY_FLOOR)
    else $error("floor not held");
  AST_TOP_END: assert property (@(posedge mclk) disable iff (rst)
    !drive_source_sel && !vin_open && vin_mv >= `FPD_VIN_HI |-> duty_sel == `FPD_DUTY_FULL)
    else $error("upper end not full duty");
  AST_BOUNDARY: assert property (@(posedge mclk) disable iff (rst)
    state == FPD_ST_RUN && !sleep_bit && !pwm_wrap |=> $stable(high_time))
    else $error("high time changed mid period");
  AST_OVERHEAT: assert property (@(posedge mclk) disable iff (rst)
    over_temp && !asleep |-> ##1 overheat_flag ##1 alarm_oe)
    else $error("overheat not reported");
  AST_STALL_SET: assert property (@(posedge mclk) disable iff (rst)
    stall_set && !asleep |=> stall_flag ##1 alarm_oe)
    else $error("stall not reported");
  AST_STALL_CLR: assert property (@(posedge mclk) disable iff (rst)
    stall_flag_clear && !stall_set |=> !stall_flag)
    else $error("stall flag not cleared");

endmodule : fpd_top

`default_nettype wire

// [verif/fpd_fan_model.sv]
// Purpose: Fan model on the far side of the drive, gives tachometer pulses
// Assumes: One mclk domain, pulses synchronous to mclk
// Notes: pulse_gap of zero models a locked rotor with no pulses
`default_nettype none

module fpd_fan_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pulse_gap,
  output logic tach_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // ====================================================
  // Pulse spacing
  logic [7:0] gap_cnt; // Cycles since the last pulse

  // One-cycle pulse every pulse_gap cycles; a gap that divides the gate
  // keeps the count per gate exact whatever the phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_cnt <= 8'h00;
      tach_pulse <= 1'b0;
    end else if (pulse_gap == 8'h00) begin
      // Locked rotor: line stays low
      gap_cnt <= 8'h00;
      tach_pulse <= 1'b0;
    end else begin
      tach_pulse <= (gap_cnt == 8'h00);
      gap_cnt <= (gap_cnt >= pulse_gap - 8'h01) ? 8'h00 : gap_cnt + 8'h01;
    end
  end
endmodule : fpd_fan_model

`default_nettype wire

// [verif/tb_fan_pwm_duty_and_speed_monitor.sv]
// Purpose: Self-checking bench for the fan drive and speed monitor
// Assumes: Shortened period, start and hold counts
// Notes: Duty is judged by counting high cycles over one full period
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %0d seen %0d", nm, e, g); end end

module tb_fan_pwm_duty_and_speed_monitor;
  import fpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ====================================================
  // Short counts keep the run small
  localparam int PER = 100;
  localparam int STC = 300;
  localparam int HLD = 1200;

  logic mclk = 1'b0, rst, sleep_bit, drive_source_sel, fine_step_select;
  logic stall_flag_clear, vin_open, tach_pulse, drive_level_wr;
  logic [1:0] pulses_per_rev_sel;
  logic [7:0] fault_threshold, pulse_gap;
  logic [11:0] vin_mv;
  logic [3:0] drive_level_wdata, drive_level;
  logic [8:0] speed_reading_reg;
  logic overheat_flag, stall_flag, speed_count_overflow, alarm_out, alarm_oe, pwm_out;
  int checked = 0, miscompares = 0, hi;

  // 50 MHz clock
  always #10 mclk = ~mclk;

  fpd_top #(.PWM_PERIOD(PER), .START_CYCLES(STC), .HOLD_CYCLES(HLD)) i_dut (
    .mclk(mclk), .rst(rst), .sleep_bit(sleep_bit), .drive_source_sel(drive_source_sel),
    .pulses_per_rev_sel(pulses_per_rev_sel), .fine_step_select(fine_step_select),
    .stall_flag_clear(stall_flag_clear), .fault_threshold(fault_threshold), .vin_mv(vin_mv),
    .vin_open(vin_open), .tach_pulse(tach_pulse), .drive_level_wr(drive_level_wr),
    .drive_level_wdata(drive_level_wdata), .drive_level(drive_level),
    .speed_reading_reg(speed_reading_reg), .overheat_flag(overheat_flag), .stall_flag(stall_flag),
    .speed_count_overflow(speed_count_overflow), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .pwm_out(pwm_out));

  fpd_fan_model i_fan (.mclk(mclk), .rst(rst), .pulse_gap(pulse_gap), .tach_pulse(tach_pulse));

  // ====================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // High cycles counted at the falling edge, where outputs are settled
  task automatic count_high(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge mclk);
      if (pwm_out === 1'b1) hi++;
    end
  endtask : count_high

  // Let a new duty reach a period boundary, then measure one period
  task automatic duty_is(input int pm);
    tick(2 * PER + 2);
    count_high(PER);
    `CHK("pwm_high", PER * pm / 1000, hi)
    // Hand back on a rising edge so the next stimulus lands there
    @(posedge mclk);
  endtask : duty_is

  // Host write of the level register, readback one cycle after
  task automatic level_write(input logic [3:0] v, input logic [3:0] e);
    @(posedge mclk);
    drive_level_wr <= 1'b1;
    drive_level_wdata <= v;
    @(posedge mclk);
    drive_level_wr <= 1'b0;
    @(negedge mclk);
    `CHK("drive_level", e, drive_level)
    @(posedge mclk);
  endtask : level_write

  // Two gates guarantee one whole gate under the new settings
  task automatic speed_is(input logic [8:0] e, input logic ov);
    tick(2 * HLD + 4);
    @(negedge mclk);
    `CHK("speed_reading_reg", e, speed_reading_reg)
    `CHK("speed_count_overflow", ov, speed_count_overflow)
    @(posedge mclk);
  endtask : speed_is

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ====================================================
  // Main sequence
  initial begin
    rst <= 1'b1;
    sleep_bit <= 1'b0;
    drive_source_sel <= 1'b0;
    pulses_per_rev_sel <= 2'h1;
    fine_step_select <= 1'b1;
    stall_flag_clear <= 1'b0;
    fault_threshold <= 8'h04;
    vin_mv <= 12'h7D0;
    vin_open <= 1'b0;
    drive_level_wr <= 1'b0;
    drive_level_wdata <= 4'h0;
    pulse_gap <= 8'h08;
    // Reset stands over two rising edges
    tick(1);
    @(negedge mclk);
    `CHK("pwm_out", 1'b0, pwm_out)
    `CHK("drive_level", 4'h2, drive_level)
    `CHK("speed_reading_reg", 9'h000, speed_reading_reg)
    `CHK("alarm_oe", 1'b0, alarm_oe)
    `CHK("alarm_out", 1'b0, alarm_out)
    @(posedge mclk);
    rst <= 1'b0;
    // Full drive over the first STC - 2 cycles of the start interval
    tick(1);
    count_high(STC - 2);
    `CHK("start_high", STC - 2, hi)
    @(posedge mclk);
    // Temperature source: floor, low end, midpoint, top end, open input
    vin_mv <= 12'h3E8;
    duty_is(300);
    vin_mv <= 12'h654;
    duty_is(300);
    vin_mv <= 12'h83E;
    duty_is(650);
    vin_mv <= 12'hA28;
    duty_is(1000);
    vin_open <= 1'b1;
    duty_is(393);
    // Host selects the register source first, then writes each code
    drive_source_sel <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      level_write(4'(k), 4'(k));
      duty_is(300 + 700 * k / 15);
    end
    // Back to temperature live, no restart; over range raises alarm
    vin_open <= 1'b0;
    drive_source_sel <= 1'b0;
    vin_mv <= 12'hA8C;
    duty_is(1000);
    @(negedge mclk);
    `CHK("overheat_flag", 1'b1, overheat_flag)
    `CHK("alarm_oe", 1'b1, alarm_oe)
    `CHK("alarm_out", 1'b0, alarm_out)
    @(posedge mclk);
    vin_mv <= 12'h7D0;
    tick(4);
    @(negedge mclk);
    `CHK("overheat_flag", 1'b0, overheat_flag)
    `CHK("alarm_oe", 1'b0, alarm_oe)
    @(posedge mclk);
    // Speed for each pulses-per-revolution choice, fine steps
    for (int p = 0; p < 4; p++) begin
      pulses_per_rev_sel <= 2'(p);
      speed_is(9'h096 >> p, 1'b0);
    end
    // Coarse steps halve the reading
    pulses_per_rev_sel <= 2'h1;
    fine_step_select <= 1'b0;
    speed_is(9'h025, 1'b0);
    // Too fast: clamp and flag, then clears after one clean gate
    fine_step_select <= 1'b1;
    pulses_per_rev_sel <= 2'h0;
    pulse_gap <= 8'h02;
    speed_is(9'h1FF, 1'b1);
    pulse_gap <= 8'h08;
    speed_is(9'h096, 1'b0);
    // Locked rotor: stall raised, drive still pulses
    pulse_gap <= 8'h00;
    for (int i = 0; i <= 3 * HLD; i++) begin
      @(negedge mclk);
      if (stall_flag === 1'b1) break;
      if (i == 3 * HLD) begin
        miscompares++;
        $display("FAIL stall_flag expected 1 seen %0d", stall_flag);
        end_sim();
      end
    end
    tick(2);
    @(negedge mclk);
    `CHK("alarm_oe", 1'b1, alarm_oe)
    duty_is(571);
    // Clear falls well inside the restarted hold, so it must win
    pulse_gap <= 8'h08;
    @(posedge mclk);
    stall_flag_clear <= 1'b1;
    @(posedge mclk);
    stall_flag_clear <= 1'b0;
    tick(2);
    @(negedge mclk);
    `CHK("stall_flag", 1'b0, stall_flag)
    `CHK("alarm_oe", 1'b0, alarm_oe)
    @(posedge mclk);
    // Sleep stops the drive, restores defaults and ignores writes
    drive_source_sel <= 1'b1;
    level_write(4'h5, 4'h5);
    sleep_bit <= 1'b1;
    tick(4);
    count_high(PER);
    `CHK("sleep_high", 0, hi)
    `CHK("drive_level", 4'h2, drive_level)
    `CHK("speed_reading_reg", 9'h000, speed_reading_reg)
    level_write(4'h9, 4'h2);
    // Wake: one edge to leave sleep, then full drive for the start interval
    @(posedge mclk);
    sleep_bit <= 1'b0;
    tick(2);
    count_high(STC - 2);
    `CHK("wake_high", STC - 2, hi)
    duty_is(393);
    end_sim();
  end
endmodule : tb_fan_pwm_duty_and_speed_monitor

`undef CHK
`default_nettype wire
